/* shared/counter_mode_pkg.sv */
// Constants and enumerations for the counter array mode control block
package counter_mode_pkg;

    // Register addresses in the special-function register space
    localparam logic [7:0] CONTROL_ADDR = 8'hd8;
    localparam logic [7:0] MODE_ADDR = 8'hd9;

    // Field positions of counter_mode_config
    localparam int IDLE_SUSPEND_BIT = 7;
    localparam int WATCHDOG_ENABLE_BIT = 6;
    localparam int WATCHDOG_LOCK_BIT = 5;
    localparam int UNUSED_BIT = 4;
    localparam int TIMEBASE_LSB = 1;
    localparam int OVERFLOW_IRQ_ENABLE_BIT = 0;

    // Field positions of counter_array_control
    localparam int OVERFLOW_FLAG_BIT = 7;
    localparam int RUN_BIT = 6;

    // Values after reset, and the top count value
    localparam logic IDLE_SUSPEND_RESET = 1'b0;
    localparam logic WATCHDOG_ENABLE_RESET = 1'b1;
    localparam logic WATCHDOG_LOCK_RESET = 1'b0;
    localparam logic [2:0] TIMEBASE_RESET = 3'h0;
    localparam logic OVERFLOW_IRQ_ENABLE_RESET = 1'b0;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] COUNT_MAX = 16'hffff;

    // Divider lengths in system clock cycles, and in external clock rising edges for EXT_CLK_DIV
    localparam int SYSCLK_DIV_SLOW = 12;
    localparam int SYSCLK_DIV_FAST = 4;
    localparam int EXT_CLK_DIV = 8;
    localparam logic [3:0] SLOW_LAST = 4'(SYSCLK_DIV_SLOW - 1);
    localparam logic [1:0] FAST_LAST = 2'(SYSCLK_DIV_FAST - 1);
    localparam logic [2:0] EXT_LAST = 3'(EXT_CLK_DIV - 1);

    // Timebase select codes
    typedef enum logic [2:0] {
        TB_SYSCLK_DIV12 = 3'b000,
        TB_SYSCLK_DIV4 = 3'b001,
        TB_TIMER0_OVF = 3'b010,
        TB_COUNT_INPUT = 3'b011,
        TB_SYSCLK = 3'b100,
        TB_EXT_CLK_DIV8 = 3'b101,
        TB_TIMER4_OVF = 3'b110,
        TB_NONE = 3'b111
    } timebase_e;

endpackage : counter_mode_pkg

/* logic/pca_counter_mode_control.sv */
// Mode control, timebase selection and main counter of the counter array
module pca_counter_mode_control
    import counter_mode_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr_en,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_rd_en,
    output logic [7:0] sfr_rdata,
    input wire logic cpu_idle,
    input wire logic timer0_overflow,
    input wire logic timer4_overflow,
    input wire logic external_count_input,
    input wire logic external_clock,
    output logic [15:0] counter_value,
    output logic counter_overflow_flag,
    output logic watchdog_active,
    output logic irq_request
);
    import counter_mode_pkg::*;

    typedef struct packed {
        logic idle_suspend;
        logic watchdog_enable;
        logic watchdog_lock;
        logic [2:0] timebase_select;
        logic overflow_irq_enable;
        logic run;
        logic overflow_flag;
        logic [15:0] count;
        logic [3:0] slow_div;
        logic [1:0] fast_div;
        logic count_in_prev;
        logic ext_meta;
        logic ext_sync;
        logic ext_prev;
        logic [2:0] ext_div;
        logic [7:0] rdata;
        logic irq;
    } state_s;

    state_s state_q;
    state_s state_d;

    logic suspended;
    logic tick;
    logic wrap;
    logic slow_tick;
    logic fast_tick;
    logic ext_edge;
    logic ext_tick;
    logic count_in_fall;
    logic mode_wr;
    logic ctrl_wr;
    logic [7:0] mode_read;
    logic [7:0] ctrl_read;

    always_comb
    begin
        state_d = state_q;

        // Idle freeze covers the dividers too, so no partial prescale leaks out
        suspended = state_q.idle_suspend & cpu_idle;

        slow_tick = (state_q.slow_div == SLOW_LAST);
        fast_tick = (state_q.fast_div == FAST_LAST);

        // External clock: two flops, then rising edge on the settled copy
        state_d.ext_meta = external_clock;
        state_d.ext_sync = state_q.ext_meta;
        state_d.ext_prev = state_q.ext_sync;
        ext_edge = state_q.ext_sync & ~state_q.ext_prev;
        ext_tick = ext_edge & (state_q.ext_div == EXT_LAST);

        // Count input looked at once per four clocks; faster edges may be missed
        count_in_fall = 1'b0;
        if (fast_tick && !suspended)
        begin
            state_d.count_in_prev = external_count_input;
            count_in_fall = state_q.count_in_prev & ~external_count_input;
        end

        if (!suspended)
        begin
            state_d.slow_div = slow_tick ? 4'h0 : state_q.slow_div + 4'h1;
            state_d.fast_div = state_q.fast_div + 2'h1;
            if (ext_edge)
            begin
                state_d.ext_div = state_q.ext_div + 3'h1;
            end
        end

        case (timebase_e'(state_q.timebase_select))
            TB_SYSCLK_DIV12: tick = slow_tick;
            TB_SYSCLK_DIV4: tick = fast_tick;
            TB_TIMER0_OVF: tick = timer0_overflow;
            TB_COUNT_INPUT: tick = count_in_fall;
            TB_SYSCLK: tick = 1'b1;
            TB_EXT_CLK_DIV8: tick = ext_tick;
            TB_TIMER4_OVF: tick = timer4_overflow;
            TB_NONE: tick = 1'b0;
            default: tick = 1'b0;
        endcase
        tick = tick & state_q.run & ~suspended;

        wrap = tick & (state_q.count == COUNT_MAX);
        if (tick)
        begin
            state_d.count = state_q.count + 16'h0001;
        end

        mode_wr = sfr_wr_en & (sfr_addr == MODE_ADDR);
        ctrl_wr = sfr_wr_en & (sfr_addr == CONTROL_ADDR);

        if (mode_wr)
        begin
            // Lock only ever sets; enable may not fall once locked
            state_d.watchdog_lock = state_q.watchdog_lock
                | sfr_wdata[WATCHDOG_LOCK_BIT];
            state_d.watchdog_enable = sfr_wdata[WATCHDOG_ENABLE_BIT]
                | state_q.watchdog_lock;
            if (!state_q.watchdog_enable)
            begin
                // Other fields change only with the watchdog off
                state_d.idle_suspend = sfr_wdata[IDLE_SUSPEND_BIT];
                state_d.timebase_select = sfr_wdata[TIMEBASE_LSB +: 3];
                state_d.overflow_irq_enable = sfr_wdata[OVERFLOW_IRQ_ENABLE_BIT];
            end
        end

        if (ctrl_wr)
        begin
            state_d.run = sfr_wdata[RUN_BIT];
            state_d.overflow_flag = sfr_wdata[OVERFLOW_FLAG_BIT];
        end
        // A wrap in the same cycle as a software clear keeps the flag set
        if (wrap)
        begin
            state_d.overflow_flag = 1'b1;
        end

        mode_read = 8'h00;
        mode_read[IDLE_SUSPEND_BIT] = state_q.idle_suspend;
        mode_read[WATCHDOG_ENABLE_BIT] = state_q.watchdog_enable;
        mode_read[WATCHDOG_LOCK_BIT] = state_q.watchdog_lock;
        mode_read[UNUSED_BIT] = 1'b0;
        mode_read[TIMEBASE_LSB +: 3] = state_q.timebase_select;
        mode_read[OVERFLOW_IRQ_ENABLE_BIT] = state_q.overflow_irq_enable;

        // Module flags of this register live elsewhere and read zero here
        ctrl_read = 8'h00;
        ctrl_read[OVERFLOW_FLAG_BIT] = state_q.overflow_flag;
        ctrl_read[RUN_BIT] = state_q.run;

        if (sfr_rd_en)
        begin
            if (sfr_addr == MODE_ADDR)
            begin
                state_d.rdata = mode_read;
            end
            else if (sfr_addr == CONTROL_ADDR)
            begin
                state_d.rdata = ctrl_read;
            end
            else
            begin
                state_d.rdata = 8'h00;
            end
        end

        state_d.irq = state_q.overflow_flag & state_q.overflow_irq_enable;
    end

    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            state_q.idle_suspend <= IDLE_SUSPEND_RESET;
            state_q.watchdog_enable <= WATCHDOG_ENABLE_RESET;
            state_q.watchdog_lock <= WATCHDOG_LOCK_RESET;
            state_q.timebase_select <= TIMEBASE_RESET;
            state_q.overflow_irq_enable <= OVERFLOW_IRQ_ENABLE_RESET;
            state_q.run <= 1'b0;
            state_q.overflow_flag <= 1'b0;
            state_q.count <= COUNT_RESET;
            state_q.slow_div <= 4'h0;
            state_q.fast_div <= 2'h0;
            state_q.count_in_prev <= 1'b0;
            state_q.ext_meta <= 1'b0;
            state_q.ext_sync <= 1'b0;
            state_q.ext_prev <= 1'b0;
            state_q.ext_div <= 3'h0;
            state_q.rdata <= 8'h00;
            state_q.irq <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    assign sfr_rdata = state_q.rdata;
    assign counter_value = state_q.count;
    assign counter_overflow_flag = state_q.overflow_flag;
    assign watchdog_active = state_q.watchdog_enable;
    assign irq_request = state_q.irq;

endmodule : pca_counter_mode_control

/* tb/pca_counter_mode_control_sva.sv */
// Port assertions for the counter mode control block
module counter_mode_checker
    import counter_mode_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr_en,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_rd_en,
    input wire logic [7:0] sfr_rdata,
    input wire logic [15:0] counter_value,
    input wire logic counter_overflow_flag,
    input wire logic watchdog_active,
    input wire logic irq_request
);
    timeunit 1ns;
    timeprecision 1ps;
    logic ctrl_wr;
    logic wd_set_wr;
    logic wd_clr_wr;
    assign ctrl_wr = sfr_wr_en && sfr_addr == CONTROL_ADDR;
    assign wd_set_wr = sfr_wr_en && sfr_addr == MODE_ADDR && sfr_wdata[WATCHDOG_ENABLE_BIT];
    assign wd_clr_wr = sfr_wr_en && sfr_addr == MODE_ADDR && !sfr_wdata[WATCHDOG_ENABLE_BIT];
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    a_wrap_sets_flag: assert property (counter_value == COUNT_MAX ##1
        counter_value == COUNT_RESET |-> counter_overflow_flag) else $error("no flag on wrap");
    a_flag_sticky: assert property (counter_overflow_flag && !ctrl_wr |=>
        counter_overflow_flag) else $error("flag cleared by hardware");
    a_flag_cause: assert property ($rose(counter_overflow_flag) |->
        $past(counter_value) == COUNT_MAX || $past(ctrl_wr)) else $error("flag set without wrap");
    a_count_step: assert property ($changed(counter_value) |->
        counter_value == 16'($past(counter_value) + 16'h1)) else $error("counter jumped");
    a_irq_needs_flag: assert property (!counter_overflow_flag |=> !irq_request)
        else $error("irq without flag");
    a_wd_rise: assert property ($rose(watchdog_active) |-> $past(wd_set_wr))
        else $error("watchdog enabled without write");
    a_wd_fall: assert property ($fell(watchdog_active) |-> $past(wd_clr_wr))
        else $error("watchdog disabled without write");
    a_unused_zero: assert property (sfr_rd_en && sfr_addr == MODE_ADDR |=>
        !sfr_rdata[UNUSED_BIT]) else $error("unused mode bit reads one");
endmodule : counter_mode_checker

bind pca_counter_mode_control counter_mode_checker u_counter_mode_checker (
    .ref_clk, .reset, .sfr_addr, .sfr_wr_en, .sfr_wdata, .sfr_rd_en, .sfr_rdata,
    .counter_value, .counter_overflow_flag, .watchdog_active, .irq_request
);

/* tb/pca_source_model.sv */
// Free-running timer overflow, count input and external clock sources
module pca_source_model (
    input wire logic ref_clk,
    input wire logic reset,
    output logic timer0_overflow,
    output logic timer4_overflow,
    output logic external_count_input,
    output logic external_clock
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] ph_q;
    // A 24-cycle cycle keeps every source a whole number of periods per window
    always_ff @(posedge ref_clk or posedge reset)
        if (reset)
            ph_q <= 5'h0;
        else
            ph_q <= (ph_q == 5'h17) ? 5'h0 : ph_q + 5'h1;
    assign timer0_overflow = ph_q[0];
    assign timer4_overflow = (ph_q % 5'h3) == 5'h0;
    assign external_clock = ph_q[1];
    assign external_count_input = ph_q[2];
endmodule : pca_source_model

/* tb/pca_counter_mode_control_tb_top.sv */
// Register-level tests of the counter mode control block
module pca_counter_mode_control_tb_top
    import counter_mode_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk, reset, sfr_wr_en, sfr_rd_en, cpu_idle;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
    logic timer0_overflow, timer4_overflow, external_count_input, external_clock;
    logic [15:0] counter_value;
    logic counter_overflow_flag, watchdog_active, irq_request;
    int mismatches, n_checks;
    logic [15:0] rates [8] = '{16'h8, 16'h18, 16'h30, 16'hc, 16'h60, 16'h3, 16'h20, 16'h0};

    pca_counter_mode_control u_pca_counter_mode_control (.ref_clk, .reset, .sfr_addr,
        .sfr_wr_en, .sfr_wdata, .sfr_rd_en, .sfr_rdata, .cpu_idle, .timer0_overflow,
        .timer4_overflow, .external_count_input, .external_clock, .counter_value,
        .counter_overflow_flag, .watchdog_active, .irq_request);
    pca_source_model u_pca_source_model (.ref_clk, .reset, .timer0_overflow,
        .timer4_overflow, .external_count_input, .external_clock);

    task automatic check_reg(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_reg

    task automatic check_cnt(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("Error at %0t: count %h expected %h", $time, got, exp);
        end
    endtask : check_cnt

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        #1;
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr_en = 1'b1;
        @(posedge ref_clk);
        #1;
        sfr_wr_en = 1'b0;
    endtask : wr

    task automatic rd_check(input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        #1;
        sfr_addr = a;
        sfr_rd_en = 1'b1;
        @(posedge ref_clk);
        #1;
        sfr_rd_en = 1'b0;
        check_reg(sfr_rdata, exp);
    endtask : rd_check

    // Counts ticks over 96 clocks after the pipelines have settled
    task automatic measure(input logic [7:0] mode, input logic idle, input logic [15:0] exp);
        logic [15:0] start;
        wr(MODE_ADDR, mode);
        cpu_idle = idle;
        repeat (8) @(posedge ref_clk);
        #1;
        start = counter_value;
        repeat (96) @(posedge ref_clk);
        #1;
        check_cnt(counter_value - start, exp);
    endtask : measure

    task automatic pulse_reset();
        reset = 1'b1;
        repeat (2) @(posedge ref_clk);
        #1;
        reset = 1'b0;
    endtask : pulse_reset

    task automatic close_out();
        $display("Checks %0d, mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : close_out

    initial
    begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    initial
    begin
        #400000;
        mismatches++;
        close_out();
    end

    initial
    begin
        {sfr_addr, sfr_wdata, sfr_wr_en, sfr_rd_en, cpu_idle} = '0;
        pulse_reset();
        rd_check(MODE_ADDR, 8'h40);
        rd_check(CONTROL_ADDR, 8'h00);
        wr(MODE_ADDR, 8'h7f);
        rd_check(MODE_ADDR, 8'h60);
        wr(MODE_ADDR, 8'h00);
        rd_check(MODE_ADDR, 8'h60);
        pulse_reset();
        rd_check(MODE_ADDR, 8'h40);
        wr(MODE_ADDR, 8'h00);
        check_reg({7'h0, watchdog_active}, 8'h00);
        wr(MODE_ADDR, 8'h1f);
        rd_check(MODE_ADDR, 8'h0f);
        wr(CONTROL_ADDR, 8'h40);
        for (int c = 0; c < 8; c++)
            measure({4'h0, 3'(c), 1'b0}, 1'b0, rates[c]);
        measure(8'h88, 1'b1, 16'h0);
        measure(8'h08, 1'b1, 16'h60);
        cpu_idle = 1'b0;
        wr(MODE_ADDR, 8'h09);
        for (int i = 0; i < 70000 && counter_value !== COUNT_MAX; i++)
        begin
            @(posedge ref_clk);
            #1;
        end
        @(posedge ref_clk);
        #1;
        check_reg({7'h0, counter_overflow_flag}, 8'h01);
        @(posedge ref_clk);
        #1;
        check_reg({7'h0, irq_request}, 8'h01);
        wr(MODE_ADDR, 8'h08);
        @(posedge ref_clk);
        #1;
        check_reg({7'h0, irq_request}, 8'h00);
        rd_check(CONTROL_ADDR, 8'hc0);
        wr(CONTROL_ADDR, 8'h40);
        rd_check(CONTROL_ADDR, 8'h40);
        rd_check(8'hda, 8'h00);
        wr(MODE_ADDR, 8'h40);
        rd_check(MODE_ADDR, 8'h40);
        close_out();
    end
endmodule : pca_counter_mode_control_tb_top
